// ==== src/tmit_cfg.svh ====
`ifndef TMIT_CFG_SVH
`define TMIT_CFG_SVH

// ----------------------------------------
// Register word offsets
// ----------------------------------------
`define TMIT_A_MASK1     6'h00
`define TMIT_A_CFG1      6'h01
`define TMIT_A_CFG2      6'h02
`define TMIT_A_CMD       6'h03
`define TMIT_A_TTAG      6'h05
`define TMIT_A_STAT1     6'h06
`define TMIT_A_QDATA     6'h08
`define TMIT_A_QIDX      6'h09
`define TMIT_A_MASK2     6'h1D
`define TMIT_A_STAT2     6'h1E

// ----------------------------------------
// Configuration 1 fields
// ----------------------------------------
`define TMIT_C1_IMODE    1:0
`define TMIT_C1_ENH      2
`define TMIT_C1_RES      5:3
`define TMIT_C1_SWINC    6
`define TMIT_C1_SYNCLR   7
`define TMIT_C1_SYNLD    8
`define TMIT_C1_SYNFLT   9
`define TMIT_C1_BCSYN    10
`define TMIT_C1_QEN      11
`define TMIT_C1_QVAL     12
`define TMIT_C1_QINV     13
`define TMIT_C1_EBC      14

// ----------------------------------------
// Configuration 2 and command fields
// ----------------------------------------
`define TMIT_C2_CSIZE    1:0
`define TMIT_C2_DSIZE    4:2
`define TMIT_CMD_ICLR    0
`define TMIT_CMD_TTINC   1
`define TMIT_CMD_STKCLR  2

// ----------------------------------------
// Status 1 bit positions
// ----------------------------------------
`define TMIT_S1_EOM      0
`define TMIT_S1_TTROLL   5
`define TMIT_S1_MTDROLL  9
`define TMIT_S1_MTCROLL  10
`define TMIT_S1_RAMPAR   12

// ----------------------------------------
// Status 2 bit positions
// ----------------------------------------
`define TMIT_S2_CHAIN    0
`define TMIT_S2_MTCHALF  4
`define TMIT_S2_MTDHALF  5
`define TMIT_S2_QROLL    8
`define TMIT_S2_USER     11

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define TMIT_RST_WORD    16'h0000
`define TMIT_PAR_MARK    16'h8000
`define TMIT_CLK_NS      10
`define TMIT_BASE_US     2
`define TMIT_NS_PER_US   1000
`define TMIT_Q_DEPTH     64

`endif

// ==== src/tmit_pkg.sv ====
package tmit_pkg;

  typedef enum logic [1:0] {
    IM_PULSE,
    IM_LVL_SW,
    IM_LVL_AUTO
  } tmit_irq_mode_t;

  typedef enum logic [1:0] {
    TM_BC,
    TM_RT,
    TM_MON,
    TM_RT_MON
  } tmit_term_mode_t;

  typedef struct packed {
    logic [15:0] mask1;
    logic [15:0] mask2;
    logic [15:0] cfg1;
    logic [15:0] cfg2;
    logic [15:0] stat1;
    logic [15:0] stat2;
    logic [15:0] ttag;
    logic [5:0]  qidx;
    logic [13:0] cptr;
    logic [15:0] dptr;
    logic        irq;
    logic [15:0] rdata;
    logic        stamp_we;
    logic [15:0] stamp;
    logic        gpq_we;
    logic [15:0] gpq;
    logic [15:0] sync_word;
  } tmit_state_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } tmit_tb_state_t;

  typedef struct packed {
    logic [5:0] wptr;
    logic       roll;
  } tmit_q_state_t;

endpackage

// ==== src/tmit_timebase.sv ====
`timescale 1ns/10ps
`include "tmit_cfg.svh"

module tmit_timebase #(
  parameter int TICK_CYCLES = 200
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Resolution select, 2 us shifted left by res_i, at most 64 us
  input  wire logic [2:0] res_i,
  // One-cycle tick
  output logic            tick_o
);

  tmit_pkg::tmit_tb_state_t s_r;
  tmit_pkg::tmit_tb_state_t s_nxt;
  logic [15:0]              limit;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    limit = 16'((TICK_CYCLES << res_i) - 1);
    s_nxt.tick = 1'b0;
    // Resolutions above 64 us are clipped to 64 us
    if (res_i > 3'h5) begin
      limit = 16'((TICK_CYCLES << 5) - 1);
    end
    if (s_r.cnt >= limit) begin
      s_nxt.cnt = 16'h0000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick_o = s_r.tick;

endmodule // tmit_timebase

// ==== src/tmit_evq.sv ====
`timescale 1ns/10ps
`include "tmit_cfg.svh"

module tmit_evq #(
  parameter int DEPTH = `TMIT_Q_DEPTH
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Entry write, two words per entry
  input  wire logic        we_i,
  input  wire logic [15:0] w0_i,
  input  wire logic [15:0] w1_i,
  // Read port
  input  wire logic [5:0]  rd_idx_i,
  output logic [15:0]      rd_data_o,
  output logic [5:0]       wptr_o,
  output logic             roll_o
);

  logic [15:0]               mem [DEPTH];
  tmit_pkg::tmit_q_state_t   s_r;
  tmit_pkg::tmit_q_state_t   s_nxt;

  // ----------------------------------------
  // Pointer and rollover
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.roll = 1'b0;
    if (we_i) begin
      s_nxt.wptr = s_r.wptr + 6'h02;
      s_nxt.roll = (s_r.wptr == 6'(DEPTH - 2));
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // No reset on storage: contents are only meaningful once written, below the pointer or anywhere after a rollover
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[s_r.wptr] <= w0_i;
      mem[s_r.wptr + 6'h01] <= w1_i;
    end
  end

  assign rd_data_o = mem[rd_idx_i];
  assign wptr_o = s_r.wptr;
  assign roll_o = s_r.roll;

endmodule // tmit_evq

// ==== src/tmit_core.sv ====
// Function
// - Monitor raises end-of-message, half and full wrap on command and data stacks.
// - Half-way event fires when a monitor stack reaches half its size.
// - RT and monitor modes keep a 64-word queue, two words per message.
// - Queue entries filtered to valid, invalid, or both message kinds.
// - Host read/write 16-bit time tag, tick 2 to 64 us selectable.
// - Optional mode where the time tag advances only on software command.
// - Current time tag handed out for each processed message descriptor.
// - Time tag wrap from FFFF to 0000 sets a status flag.
// - RT sync without data clears, sync with data loads the time tag.
// - With filtering, sync data loads only when its LSB is zero.
// - BC may send the time tag as the sync-with-data word.
// - BC sequencer can load the time tag and copy it to its queue.
// - Interrupt output is pulse, software-cleared level, or read-cleared level.
// - Standard mode sets status only when the event's mask bit is on.
// - Enhanced mode always sets status; mask gates only the request.
// - Status 2 bit 0 shows a pending interrupt in status 1.
// - Status 1 covers parity, timeout, rollovers, handshake, retry, mode code, EOM.
// - Status 2 covers self-test, half rollovers, opcode faults, queue rollover, trap.
// - Enhanced BC offers four user interrupt bits raised by the sequencer.
// - Time tag keeps counting through self-test and is not restored.
// - RAM parity error address is logged in the queue when enabled.
`timescale 1ns/10ps
`include "tmit_cfg.svh"

module tmit_core #(
  parameter int TICK_CYCLES = `TMIT_BASE_US * `TMIT_NS_PER_US / `TMIT_CLK_NS
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Register port
  input  wire logic        reg_sel_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_wr_i,
  input  wire logic [5:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic [15:0]      reg_rdata_o,
  // Terminal mode
  input  wire logic [1:0]  term_mode_i,
  // Raw event pulses for both status registers
  input  wire logic [15:0] ev1_i,
  input  wire logic [15:0] ev2_i,
  // Monitor stack writes
  input  wire logic        mon_cmd_push_i,
  input  wire logic        mon_data_push_i,
  // Message completion and queue data
  input  wire logic        msg_done_i,
  input  wire logic        msg_irq_i,
  input  wire logic        msg_valid_i,
  input  wire logic [15:0] msg_status_i,
  input  wire logic [15:0] msg_ptr_i,
  // RAM parity
  input  wire logic        ram_par_err_i,
  input  wire logic [15:0] ram_par_addr_i,
  // RT synchronize mode commands
  input  wire logic        rt_sync_i,
  input  wire logic        rt_sync_data_i,
  input  wire logic [15:0] rt_sync_word_i,
  // BC sequencer
  input  wire logic        bc_tt_load_i,
  input  wire logic [15:0] bc_tt_value_i,
  input  wire logic        bc_tt_copy_i,
  input  wire logic [3:0]  bc_user_irq_i,
  input  wire logic [15:0] bc_sync_user_i,
  // Outputs
  output logic             irq_o,
  output logic             stamp_we_o,
  output logic [15:0]      stamp_o,
  output logic             gpq_we_o,
  output logic [15:0]      gpq_data_o,
  output logic [15:0]      bc_sync_word_o
);

  tmit_pkg::tmit_state_t     s_r;
  tmit_pkg::tmit_state_t     s_nxt;
  tmit_pkg::tmit_irq_mode_t  imode;
  logic                      tick;
  logic                      rd;
  logic                      wr;
  logic                      inc;
  logic                      q_we;
  logic [15:0]               q_w0;
  logic [15:0]               q_w1;
  logic [15:0]               q_rdata;
  logic [5:0]                q_wptr;
  logic                      q_roll;
  logic [15:0]               ev1;
  logic [15:0]               ev2;
  logic [15:0]               set1;
  logic [15:0]               set2;
  logic [15:0]               clr1;
  logic [15:0]               clr2;
  logic [16:0]               csize;
  logic [16:0]               dsize;
  logic                      newreq;
  logic                      qmode;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [16:0] cmd_size(input logic [1:0] sel);
    cmd_size = 17'h00100 << {sel, 1'b0};
  endfunction

  function automatic logic [16:0] data_size(input logic [2:0] sel);
    data_size = 17'h00200 << sel;
  endfunction

  function automatic logic is_reg(input logic [5:0] a, input logic [5:0] b);
    is_reg = (a == b);
  endfunction

  // ----------------------------------------
  // Time base and event queue
  // ----------------------------------------
  tmit_timebase #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tb (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .res_i   (s_r.cfg1[`TMIT_C1_RES]),
    .tick_o  (tick)
  );

  tmit_evq #(
    .DEPTH (`TMIT_Q_DEPTH)
  ) u_q (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .we_i      (q_we),
    .w0_i      (q_w0),
    .w1_i      (q_w1),
    .rd_idx_i  (s_r.qidx),
    .rd_data_o (q_rdata),
    .wptr_o    (q_wptr),
    .roll_o    (q_roll)
  );

  // ----------------------------------------
  // Queue entry selection
  // ----------------------------------------
  always_comb begin
    qmode = s_r.cfg1[`TMIT_C1_QEN] &&
            (tmit_pkg::tmit_term_mode_t'(term_mode_i) != tmit_pkg::TM_BC);
    q_we = 1'b0;
    q_w0 = `TMIT_RST_WORD;
    q_w1 = `TMIT_RST_WORD;
    // Parity wins a shared cycle; the message entry is then dropped
    if (qmode && ram_par_err_i) begin
      q_we = 1'b1;
      q_w0 = `TMIT_PAR_MARK;
      q_w1 = ram_par_addr_i;
    end else if (qmode && msg_irq_i &&
                 ((msg_valid_i && s_r.cfg1[`TMIT_C1_QVAL]) ||
                  (!msg_valid_i && s_r.cfg1[`TMIT_C1_QINV]))) begin
      q_we = 1'b1;
      q_w0 = {1'b0, msg_valid_i, msg_status_i[13:0]};
      q_w1 = msg_ptr_i;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    rd = reg_sel_i && reg_rd_i;
    wr = reg_sel_i && reg_wr_i;
    imode = tmit_pkg::tmit_irq_mode_t'(s_r.cfg1[`TMIT_C1_IMODE]);
    csize = cmd_size(s_r.cfg2[`TMIT_C2_CSIZE]);
    dsize = data_size(s_r.cfg2[`TMIT_C2_DSIZE]);
    s_nxt.stamp_we = 1'b0;
    s_nxt.gpq_we = 1'b0;
    ev1 = ev1_i;
    ev2 = ev2_i;
    ev2[`TMIT_S2_CHAIN] = 1'b0;

    // Host writes
    if (wr) begin
      unique case (reg_addr_i)
        `TMIT_A_MASK1: s_nxt.mask1 = reg_wdata_i;
        `TMIT_A_MASK2: s_nxt.mask2 = reg_wdata_i;
        `TMIT_A_CFG1:  s_nxt.cfg1 = reg_wdata_i;
        `TMIT_A_CFG2:  s_nxt.cfg2 = reg_wdata_i;
        `TMIT_A_QIDX:  s_nxt.qidx = reg_wdata_i[5:0];
        default: ;
      endcase
    end

    // Time tag: counts on through self-test, no save or restore
    inc = s_r.cfg1[`TMIT_C1_SWINC] ?
          (wr && is_reg(reg_addr_i, `TMIT_A_CMD) && reg_wdata_i[`TMIT_CMD_TTINC]) :
          tick;
    if (wr && is_reg(reg_addr_i, `TMIT_A_TTAG)) begin
      s_nxt.ttag = reg_wdata_i;
    end else if (bc_tt_load_i) begin
      s_nxt.ttag = bc_tt_value_i;
    end else if (rt_sync_i && s_r.cfg1[`TMIT_C1_SYNCLR]) begin
      s_nxt.ttag = 16'h0000;
    end else if (rt_sync_data_i && s_r.cfg1[`TMIT_C1_SYNLD] &&
                 !(s_r.cfg1[`TMIT_C1_SYNFLT] && rt_sync_word_i[0])) begin
      s_nxt.ttag = rt_sync_word_i;
    end else if (inc) begin
      s_nxt.ttag = s_r.ttag + 16'h0001;
      ev1[`TMIT_S1_TTROLL] = ev1_i[`TMIT_S1_TTROLL] || (s_r.ttag == 16'hFFFF);
    end

    // Time tag consumers
    if (msg_done_i) begin
      s_nxt.stamp_we = 1'b1;
      s_nxt.stamp = s_r.ttag;
    end
    if (bc_tt_copy_i) begin
      s_nxt.gpq_we = 1'b1;
      s_nxt.gpq = s_r.ttag;
    end
    s_nxt.sync_word = s_r.cfg1[`TMIT_C1_BCSYN] ? s_r.ttag : bc_sync_user_i;

    // Monitor stacks
    if (wr && is_reg(reg_addr_i, `TMIT_A_CMD) && reg_wdata_i[`TMIT_CMD_STKCLR]) begin
      s_nxt.cptr = 14'h0000;
      s_nxt.dptr = 16'h0000;
    end else begin
      if (mon_cmd_push_i) begin
        if (17'(s_r.cptr) + 17'h00001 >= csize) begin
          s_nxt.cptr = 14'h0000;
          ev1[`TMIT_S1_MTCROLL] = 1'b1;
        end else begin
          s_nxt.cptr = s_r.cptr + 14'h0001;
          ev2[`TMIT_S2_MTCHALF] = ev2_i[`TMIT_S2_MTCHALF] ||
                                  (17'(s_r.cptr) + 17'h00001 == (csize >> 1));
        end
      end
      if (mon_data_push_i) begin
        if (17'(s_r.dptr) + 17'h00001 >= dsize) begin
          s_nxt.dptr = 16'h0000;
          ev1[`TMIT_S1_MTDROLL] = 1'b1;
        end else begin
          s_nxt.dptr = s_r.dptr + 16'h0001;
          ev2[`TMIT_S2_MTDHALF] = ev2_i[`TMIT_S2_MTDHALF] ||
                                  (17'(s_r.dptr) + 17'h00001 == (dsize >> 1));
        end
      end
    end

    // Internal event sources
    ev1[`TMIT_S1_EOM] = ev1[`TMIT_S1_EOM] || msg_done_i;
    ev1[`TMIT_S1_RAMPAR] = ev1[`TMIT_S1_RAMPAR] || ram_par_err_i;
    ev2[`TMIT_S2_QROLL] = ev2_i[`TMIT_S2_QROLL] || q_roll;
    if (s_r.cfg1[`TMIT_C1_EBC]) begin
      ev2[`TMIT_S2_USER +: 4] = ev2_i[`TMIT_S2_USER +: 4] | bc_user_irq_i;
    end

    // Status update: a new event wins over the read clear
    set1 = s_r.cfg1[`TMIT_C1_ENH] ? ev1 : (ev1 & s_r.mask1);
    set2 = s_r.cfg1[`TMIT_C1_ENH] ? ev2 : (ev2 & s_r.mask2);
    clr1 = (rd && is_reg(reg_addr_i, `TMIT_A_STAT1)) ? 16'hFFFF : 16'h0000;
    clr2 = (rd && is_reg(reg_addr_i, `TMIT_A_STAT2)) ? 16'hFFFF : 16'h0000;
    s_nxt.stat1 = (s_r.stat1 & ~clr1) | set1;
    s_nxt.stat2 = (s_r.stat2 & ~clr2) | set2;
    s_nxt.stat2[`TMIT_S2_CHAIN] = |(s_nxt.stat1 & s_r.mask1);

    // Interrupt output
    newreq = |(ev1 & s_r.mask1) || |(ev2 & s_r.mask2);
    unique case (imode)
      tmit_pkg::IM_LVL_SW: begin
        s_nxt.irq = newreq || (s_r.irq && !(wr && is_reg(reg_addr_i, `TMIT_A_CMD) &&
                                         reg_wdata_i[`TMIT_CMD_ICLR]));
      end
      tmit_pkg::IM_LVL_AUTO: begin
        s_nxt.irq = newreq || (s_r.irq && !(clr1[0] || clr2[0]));
      end
      // Code 3 is not a defined mode and behaves as pulse
      default: begin
        s_nxt.irq = newreq;
      end
    endcase

    // Read data, one cycle after the read strobe
    s_nxt.rdata = `TMIT_RST_WORD;
    if (rd) begin
      unique case (reg_addr_i)
        `TMIT_A_MASK1: s_nxt.rdata = s_r.mask1;
        `TMIT_A_MASK2: s_nxt.rdata = s_r.mask2;
        `TMIT_A_CFG1:  s_nxt.rdata = s_r.cfg1;
        `TMIT_A_CFG2:  s_nxt.rdata = s_r.cfg2;
        `TMIT_A_TTAG:  s_nxt.rdata = s_r.ttag;
        `TMIT_A_STAT1: s_nxt.rdata = s_r.stat1;
        `TMIT_A_STAT2: s_nxt.rdata = s_r.stat2;
        `TMIT_A_QDATA: s_nxt.rdata = q_rdata;
        `TMIT_A_QIDX:  s_nxt.rdata = {10'h000, q_wptr};
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata_o = s_r.rdata;
  assign irq_o = s_r.irq;
  assign stamp_we_o = s_r.stamp_we;
  assign stamp_o = s_r.stamp;
  assign gpq_we_o = s_r.gpq_we;
  assign gpq_data_o = s_r.gpq;
  assign bc_sync_word_o = s_r.sync_word;

endmodule // tmit_core

// ==== tb/tmit_core_asserts.sv ====
`timescale 1ns/10ps
`include "tmit_cfg.svh"

module tmit_core_chk (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        reset_i,
  // Register port
  input wire logic        reg_sel_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_wr_i,
  input wire logic [5:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  // Events and sequencer
  input wire logic [15:0] ev1_i,
  input wire logic [15:0] ev2_i,
  input wire logic        msg_done_i,
  input wire logic        rt_sync_i,
  input wire logic        rt_sync_data_i,
  input wire logic        bc_tt_load_i,
  input wire logic        bc_tt_copy_i,
  input wire logic [15:0] bc_sync_user_i,
  // Outputs
  input wire logic        irq_o,
  input wire logic        stamp_we_o,
  input wire logic [15:0] stamp_o,
  input wire logic        gpq_we_o,
  input wire logic [15:0] bc_sync_word_o
);
  // ----
  // Shadow copies of control registers
  // ----
  logic [15:0] cfg_r;
  logic [15:0] m1_r;
  logic [15:0] m2_r;
  wire logic   wr_w = reg_sel_i & reg_wr_i;
  wire logic   rd_w = reg_sel_i & reg_rd_i;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg_r <= 16'h0000;
      m1_r  <= 16'h0000;
      m2_r  <= 16'h0000;
    end else if (wr_w) begin
      if (reg_addr_i == `TMIT_A_CFG1) cfg_r <= reg_wdata_i;
      if (reg_addr_i == `TMIT_A_MASK1) m1_r <= reg_wdata_i;
      if (reg_addr_i == `TMIT_A_MASK2) m2_r <= reg_wdata_i;
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Other time tag writers stay idle
  sequence s_quiet;
    !wr_w && !bc_tt_load_i && !rt_sync_i && !rt_sync_data_i;
  endsequence
  sequence s_tt_wr;
    wr_w && reg_addr_i == `TMIT_A_TTAG && cfg_r[`TMIT_C1_SWINC];
  endsequence
  sequence s_copy;
    bc_tt_copy_i ##1 !bc_tt_copy_i;
  endsequence
  property p_rd_idle;
    !$past(rd_w) |-> reg_rdata_o == 16'h0000;
  endproperty
  property p_ttag_wr;
    s_tt_wr ##1 s_quiet ##1 (s_quiet and rd_w && reg_addr_i == `TMIT_A_TTAG)
      |=> reg_rdata_o == $past(reg_wdata_i, 3);
  endproperty
  property p_stamp;
    stamp_we_o == $past(msg_done_i);
  endproperty
  property p_gpq;
    s_copy |-> gpq_we_o ##1 !gpq_we_o;
  endproperty
  property p_sync_user;
    !$past(reset_i) && !$past(cfg_r[`TMIT_C1_BCSYN]) |-> bc_sync_word_o == $past(bc_sync_user_i);
  endproperty
  property p_sync_tt;
    cfg_r[`TMIT_C1_BCSYN] && msg_done_i |=> stamp_o == bc_sync_word_o;
  endproperty
  property p_irq_ev;
    (|(ev1_i & m1_r)) || (|(ev2_i[15:1] & m2_r[15:1])) |=> irq_o;
  endproperty
  property p_lvl_hold;
    cfg_r[1:0] == 2'h1 && irq_o && !(wr_w && reg_addr_i == `TMIT_A_CMD && reg_wdata_i[0])
      && !(wr_w && reg_addr_i == `TMIT_A_CFG1) |=> irq_o;
  endproperty
  property p_auto_hold;
    cfg_r[1:0] == 2'h2 && irq_o && !(rd_w && reg_addr_i inside {`TMIT_A_STAT1, `TMIT_A_STAT2})
      && !(wr_w && reg_addr_i == `TMIT_A_CFG1) |=> irq_o;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_ttag_wr: assert property (p_ttag_wr) else $error("time tag readback wrong");
  a_stamp: assert property (p_stamp) else $error("stamp strobe wrong");
  a_gpq: assert property (p_gpq) else $error("queue copy strobe wrong");
  a_sync_user: assert property (p_sync_user) else $error("sync word not user");
  a_sync_tt: assert property (p_sync_tt) else $error("sync word not time tag");
  a_irq_ev: assert property (p_irq_ev) else $error("masked event gave no irq");
  a_lvl_hold: assert property (p_lvl_hold) else $error("level irq dropped");
  a_auto_hold: assert property (p_auto_hold) else $error("auto irq dropped");
endmodule // tmit_core_chk

bind tmit_core tmit_core_chk chk_u (.*);

// ==== tb/tmit_host_mdl.sv ====
`timescale 1ns/10ps

module tmit_host_mdl (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Interrupt line from the terminal
  input  wire logic        irq_i,
  // Interrupts taken by the host
  output logic [15:0]      irq_cnt_o
);
  // Counts rising edges only, so a held level is one service request
  logic irq_q_r;
  always_ff @(posedge clk_i) begin
    irq_q_r <= reset_i ? 1'b0 : irq_i;
    if (reset_i) irq_cnt_o <= 16'h0000;
    else if (irq_i && !irq_q_r) irq_cnt_o <= irq_cnt_o + 16'h0001;
  end
endmodule // tmit_host_mdl

// ==== tb/tb_tmit_core.sv ====
`timescale 1ns/10ps
`include "tmit_cfg.svh"

module tb_tmit_core;
  // ----
  // Stimulus and observed signals
  // ----
  logic        clk_i = 1'b0;
  logic        reset_i;
  logic        reg_sel_i, reg_rd_i, reg_wr_i, vld, irq_o, stamp_we_o, gpq_we_o;
  logic [5:0]  reg_addr_i;
  logic [8:0]  p;
  logic [3:0]  usr;
  logic [1:0]  term_mode_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, ev1_i, ev2_i, dv, dw, stamp_o, gpq_data_o;
  logic [15:0] bc_sync_word_o, irq_cnt, q;
  logic [5:0]  ra [8] = '{`TMIT_A_MASK1, `TMIT_A_CFG1, `TMIT_A_CFG2, `TMIT_A_STAT1,
                          `TMIT_A_STAT2, `TMIT_A_MASK2, `TMIT_A_QIDX, 6'h04};
  logic [15:0] qe [4] = '{16'h4123, 16'h0456, 16'h8000, 16'h0777};
  int          error_cnt = 0;
  int          checked = 0;
  always #5 clk_i = ~clk_i;
  tmit_core #(.TICK_CYCLES(4)) dut_u (
    .clk_i, .reset_i, .reg_sel_i, .reg_rd_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .term_mode_i, .ev1_i, .ev2_i,
    .mon_cmd_push_i(p[0]), .mon_data_push_i(p[1]), .msg_done_i(p[2]), .msg_irq_i(p[3]),
    .msg_valid_i(vld), .msg_status_i(dv), .msg_ptr_i(dw), .ram_par_err_i(p[4]),
    .ram_par_addr_i(dw), .rt_sync_i(p[5]), .rt_sync_data_i(p[6]), .rt_sync_word_i(dv),
    .bc_tt_load_i(p[7]), .bc_tt_value_i(dv), .bc_tt_copy_i(p[8]), .bc_user_irq_i(usr),
    .bc_sync_user_i(dw), .irq_o, .stamp_we_o, .stamp_o, .gpq_we_o, .gpq_data_o,
    .bc_sync_word_o
  );
  tmit_host_mdl host_u (.clk_i, .reset_i, .irq_i(irq_o), .irq_cnt_o(irq_cnt));
  // ----
  // Access and compare tasks
  // ----
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cirq(input string nm, input logic e);
    chk(nm, {15'h0, e}, {15'h0, irq_o});
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge clk_i);
    {reg_sel_i, reg_wr_i, reg_addr_i, reg_wdata_i} = {2'b11, a, d};
    @(negedge clk_i);
    {reg_sel_i, reg_wr_i} = 2'b00;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(negedge clk_i);
    {reg_sel_i, reg_rd_i, reg_addr_i} = {2'b11, a};
    @(negedge clk_i);
    d = reg_rdata_o;
    {reg_sel_i, reg_rd_i} = 2'b00;
  endtask
  task automatic rchk(input string nm, input logic [5:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask
  task automatic pul(input logic [8:0] m, input int n);
    @(negedge clk_i);
    p = m;
    repeat (n) @(negedge clk_i);
    p = 9'h000;
  endtask
  task automatic ev(input logic [15:0] a, input logic [15:0] b);
    @(negedge clk_i);
    {ev1_i, ev2_i} = {a, b};
    @(negedge clk_i);
    {ev1_i, ev2_i} = '0;
  endtask
  task automatic conclude;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_i);
    error_cnt++;
    conclude();
  end
  // ----
  // Scenarios
  // ----
  initial begin
    {reg_sel_i, reg_rd_i, reg_wr_i, reg_addr_i, reg_wdata_i, term_mode_i} = '0;
    {p, vld, usr, ev1_i, ev2_i, dv, dw} = '0;
    reset_i = 1'b1;
    repeat (2) @(negedge clk_i);
    reset_i = 1'b0;
    foreach (ra[i]) rchk("reset", ra[i], 16'h0000);
    wr(`TMIT_A_MASK1, 16'h0002);
    ev(16'h0006, 16'h0000);
    cirq("irq", 1'b1);
    @(negedge clk_i);
    cirq("pulse", 1'b0);
    chk("irq_cnt", 16'h0001, irq_cnt);
    rchk("chain", `TMIT_A_STAT2, 16'h0001);
    rchk("std", `TMIT_A_STAT1, 16'h0002);
    rchk("rd_clr", `TMIT_A_STAT1, 16'h0000);
    wr(`TMIT_A_CFG1, 16'h0004);
    wr(`TMIT_A_MASK2, 16'h0008);
    ev(16'h0008, 16'h0000);
    cirq("enh_gate", 1'b0);
    rchk("enh", `TMIT_A_STAT1, 16'h0008);
    ev(16'h0000, 16'h0008);
    cirq("irq2", 1'b1);
    rchk("stat2", `TMIT_A_STAT2, 16'h0008);
    wr(`TMIT_A_CFG1, 16'h0001);
    ev(16'h0002, 16'h0000);
    rchk("lvl", `TMIT_A_STAT1, 16'h0002);
    cirq("lvl_sw", 1'b1);
    wr(`TMIT_A_CMD, 16'h0001);
    @(negedge clk_i);
    cirq("sw_clr", 1'b0);
    wr(`TMIT_A_CFG1, 16'h0002);
    ev(16'h0002, 16'h0000);
    repeat (2) @(negedge clk_i);
    cirq("lvl_auto", 1'b1);
    rchk("auto", `TMIT_A_STAT2, 16'h0001);
    cirq("auto_clr", 1'b0);
    rchk("auto_s1", `TMIT_A_STAT1, 16'h0002);
    wr(`TMIT_A_MASK1, 16'h0020);
    wr(`TMIT_A_CFG1, 16'h0040);
    wr(`TMIT_A_TTAG, 16'hFFFE);
    rchk("tt_rw", `TMIT_A_TTAG, 16'hFFFE);
    repeat (20) @(negedge clk_i);
    rchk("sw_hold", `TMIT_A_TTAG, 16'hFFFE);
    wr(`TMIT_A_CMD, 16'h0002);
    wr(`TMIT_A_CMD, 16'h0002);
    rchk("wrap", `TMIT_A_TTAG, 16'h0000);
    rchk("roll", `TMIT_A_STAT1, 16'h0020);
    // Resolutions rise monotonically so a running prescaler never overshoots
    for (int r = 0; r <= 6; r++) begin
      wr(`TMIT_A_CFG1, 16'(r << 3));
      wr(`TMIT_A_TTAG, 16'h0000);
      repeat (4 * (4 << ((r > 5) ? 5 : r)) - 2) @(negedge clk_i);
      rd(`TMIT_A_TTAG, q);
      chk("tick", 16'h0001, {15'h0, q >= 16'h0003 && q <= 16'h0005});
    end
    term_mode_i = 2'h1;
    wr(`TMIT_A_MASK1, 16'h0001);
    wr(`TMIT_A_CFG1, 16'h07C0);
    wr(`TMIT_A_TTAG, 16'h1234);
    pul(9'h020, 1);
    rchk("sync_clr", `TMIT_A_TTAG, 16'h0000);
    dv = 16'h5678;
    pul(9'h040, 1);
    rchk("sync_ld", `TMIT_A_TTAG, 16'h5678);
    dv = 16'h0001;
    pul(9'h040, 1);
    rchk("sync_flt", `TMIT_A_TTAG, 16'h5678);
    dv = 16'h9ABC;
    pul(9'h080, 1);
    rchk("bc_ld", `TMIT_A_TTAG, 16'h9ABC);
    pul(9'h104, 1);
    chk("gpq", 16'h9ABC, gpq_data_o);
    chk("stamp", 16'h9ABC, stamp_o);
    chk("sync_tt", 16'h9ABC, bc_sync_word_o);
    rchk("eom", `TMIT_A_STAT1, 16'h0001);
    dw = 16'h0F0F;
    wr(`TMIT_A_MASK2, 16'h7800);
    for (int k = 0; k < 2; k++) begin
      wr(`TMIT_A_CFG1, (k == 1) ? 16'h4040 : 16'h0040);
      usr = 4'h5;
      @(negedge clk_i);
      usr = 4'h0;
      rchk("user", `TMIT_A_STAT2, (k == 1) ? 16'h2800 : 16'h0000);
    end
    chk("sync_user", 16'h0F0F, bc_sync_word_o);
    term_mode_i = 2'h2;
    wr(`TMIT_A_MASK1, 16'h0600);
    wr(`TMIT_A_MASK2, 16'h0030);
    pul(9'h003, 127);
    rchk("half_pre", `TMIT_A_STAT2, 16'h0000);
    pul(9'h003, 1);
    rchk("cmd_half", `TMIT_A_STAT2, 16'h0010);
    pul(9'h003, 128);
    rchk("dat_half", `TMIT_A_STAT2, 16'h0021);
    rchk("cmd_full", `TMIT_A_STAT1, 16'h0400);
    pul(9'h002, 256);
    rchk("dat_full", `TMIT_A_STAT1, 16'h0200);
    term_mode_i = 2'h0;
    wr(`TMIT_A_CFG1, 16'h1840);
    wr(`TMIT_A_MASK2, 16'h0100);
    {vld, dv, dw} = {1'b1, 16'h4123, 16'h0456};
    pul(9'h008, 1);
    rchk("q_bc", `TMIT_A_QIDX, 16'h0000);
    term_mode_i = 2'h1;
    pul(9'h008, 1);
    vld = 1'b0;
    pul(9'h008, 1);
    rchk("q_flt", `TMIT_A_QIDX, 16'h0002);
    dw = 16'h0777;
    pul(9'h010, 1);
    for (int i = 0; i < 4; i++) begin
      wr(`TMIT_A_QIDX, 16'(i));
      rchk("q_data", `TMIT_A_QDATA, qe[i]);
    end
    wr(`TMIT_A_CFG1, 16'h3840);
    pul(9'h008, 30);
    rchk("q_wrap", `TMIT_A_QIDX, 16'h0000);
    rchk("q_roll", `TMIT_A_STAT2, 16'h0100);
    wr(`TMIT_A_QIDX, 16'h0004);
    rchk("q_inv", `TMIT_A_QDATA, 16'h4123 & 16'h3FFF);
    conclude();
  end
endmodule // tb_tmit_core
